// >>> bil_top.sv
// boot image loader: strap select, quad flash boot, spi slave boot, peripheral master
`timescale 1ns/100ps
module bil_top
    import bil_pkg::*;
#(
    parameter logic [7:0]  FLASH_HALF = FLASH_HALF_DEF,
    parameter int unsigned PER_HALF   = PER_HALF_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] flash_line_in,
    output logic [3:0]      flash_line_out,
    output logic [3:0]      flash_line_oe_n,
    output logic            flash_cs_n,
    input  wire logic       sclk_in,
    output logic            sclk_out,
    output logic            sclk_oe_n,
    input  wire logic       scs_n_in,
    output logic            scs_n_out,
    output logic            scs_n_oe_n,
    input  wire logic       smosi_in,
    output logic            smosi_out,
    output logic            smosi_oe_n,
    input  wire logic       smiso_in,
    output logic            smiso_out,
    output logic            smiso_oe_n,
    output logic [7:0]      img_data,
    output logic            img_valid,
    input  wire logic       boot_ok,
    output logic            boot_slave,
    output logic            booted,
    input  wire logic       per_start,
    input  wire logic [7:0] per_wr_len,
    input  wire logic [7:0] per_rd_len,
    input  wire logic [7:0] per_wdata,
    input  wire logic       per_wvalid,
    output logic            per_wready,
    output logic [7:0]      per_rdata,
    output logic            per_rvalid,
    output logic            per_busy
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bil_state_t st;
        logic [1:0] strap_wait;
        logic       slave;
        logic       booted;
        logic [7:0] s1;
        logic [7:0] s2;
        logic       sclk_d;
        logic [7:0] cnt;
        logic [4:0] bitc;
        logic [3:0] lo_nib;
        logic       nib_hi;
        logic [7:0] sbyte;
        logic [2:0] sbit;
        logic [7:0] img_data;
        logic       img_valid;
        logic       fcs_n;
        logic [3:0] line_out;
        logic [3:0] line_oe_n;
        logic       sclk_out;
        logic       sclk_oe_n;
        logic       scs_out;
        logic       scs_oe_n;
        logic       smosi_out;
        logic       smosi_oe_n;
        logic       smiso_out;
        logic       smiso_oe_n;
    } bil_top_t;

    // all pins released and flash deselected out of reset
    localparam bil_top_t TOP_RST = '{
        st: ST_STRAP, fcs_n: 1'b1, line_oe_n: 4'hF, sclk_oe_n: 1'b1,
        scs_out: 1'b1, scs_oe_n: 1'b1, smosi_oe_n: 1'b1, smiso_oe_n: 1'b1,
        default: '0
    };
    localparam logic [7:0] FHALF_M1 = FLASH_HALF - 8'h01;

    bil_top_t   s_reg;
    bil_top_t   s_next;
    logic       pm_sclk;
    logic       pm_cs_n;
    logic       pm_mosi;
    logic       fall;
    logic       srise;

    // ------------------------------------------------------------
    // peripheral master
    // ------------------------------------------------------------
    bil_per_master #(
        .HALF_CYC (PER_HALF)
    ) u_pm (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (per_start & s_reg.booted),
        .wr_len  (per_wr_len),
        .rd_len  (per_rd_len),
        .wdata   (per_wdata),
        .wvalid  (per_wvalid),
        .wready  (per_wready),
        .rdata   (per_rdata),
        .rvalid  (per_rvalid),
        .busy    (per_busy),
        .sclk    (pm_sclk),
        .cs_n    (pm_cs_n),
        .mosi    (pm_mosi),
        .miso    (s_reg.s2[SY_SMISO])
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next           = s_reg;
        s_next.s1        = {smiso_in, smosi_in, scs_n_in, sclk_in, flash_line_in};
        s_next.s2        = s_reg.s1;
        s_next.sclk_d    = s_reg.s2[SY_SCLK];
        s_next.img_valid = 1'b0;
        fall             = 1'b0;
        srise            = s_reg.s2[SY_SCLK] & ~s_reg.sclk_d;

        // flash clock divider; pin data moves on its falling edge
        if (s_reg.st == ST_FCMD || s_reg.st == ST_FADDR ||
            s_reg.st == ST_FDUMMY || s_reg.st == ST_FDATA) begin
            s_next.cnt = s_reg.cnt + 8'h01;
            if (s_reg.cnt == FHALF_M1) begin
                s_next.cnt      = 8'h00;
                s_next.sclk_out = ~s_reg.sclk_out;
                fall            = s_reg.sclk_out;
            end
        end

        unique case (s_reg.st)
            ST_STRAP: begin
                s_next.strap_wait = s_reg.strap_wait + 2'h1;
                if (s_reg.strap_wait == STRAP_WAIT) begin
                    if (s_reg.s2[SY_STRAP]) begin
                        s_next.st         = ST_SRECV;
                        s_next.slave      = 1'b1;
                        s_next.smiso_oe_n = 1'b0;
                        s_next.smiso_out  = 1'b0;
                    end else begin
                        s_next.st          = ST_FCMD;
                        s_next.fcs_n       = 1'b0;
                        s_next.sclk_oe_n   = 1'b0;
                        s_next.sclk_out    = 1'b0;
                        s_next.line_oe_n   = 4'hE;
                        s_next.line_out    = {3'h0, FLASH_RD_OPC[7]};
                        s_next.bitc        = 5'h00;
                        s_next.cnt         = 8'h00;
                    end
                end
            end
            ST_FCMD: begin
                if (fall) begin
                    if (s_reg.bitc == FLASH_OPC_BITS - 5'h01) begin
                        s_next.st        = ST_FADDR;
                        s_next.bitc      = 5'h00;
                        s_next.line_oe_n = 4'h0;
                        s_next.line_out  = bil_addr_nib(5'h00);
                    end else begin
                        s_next.bitc     = s_reg.bitc + 5'h01;
                        s_next.line_out = {3'h0, FLASH_RD_OPC[3'h6 - s_reg.bitc[2:0]]};
                    end
                end
            end
            ST_FADDR: begin
                if (fall) begin
                    // three address bytes over four lines
                    if (s_reg.bitc == FLASH_ADDR_NIBS - 5'h01) begin
                        s_next.st        = ST_FDUMMY;
                        s_next.bitc      = 5'h00;
                        s_next.line_oe_n = 4'hF;
                    end else begin
                        s_next.bitc     = s_reg.bitc + 5'h01;
                        s_next.line_out = bil_addr_nib(s_reg.bitc + 5'h01);
                    end
                end
            end
            ST_FDUMMY: begin
                if (fall) begin
                    s_next.bitc = s_reg.bitc + 5'h01;
                    if (s_reg.bitc == FLASH_DUMMY_NIBS - 5'h01) begin
                        s_next.st     = ST_FDATA;
                        s_next.nib_hi = 1'b0;
                    end
                end
            end
            ST_FDATA: begin
                if (fall) begin
                    if (!s_reg.nib_hi) begin
                        s_next.lo_nib = s_reg.s2[3:0];
                        s_next.nib_hi = 1'b1;
                    end else begin
                        s_next.img_data  = {s_reg.s2[3:0], s_reg.lo_nib};
                        s_next.img_valid = 1'b1;
                        s_next.nib_hi    = 1'b0;
                    end
                end
            end
            ST_SRECV: begin
                if (s_reg.s2[SY_SCS]) begin
                    s_next.sbit = 3'h0;
                end else if (srise) begin
                    s_next.sbyte = {s_reg.s2[SY_SMOSI], s_reg.sbyte[7:1]};
                    s_next.sbit  = s_reg.sbit + 3'h1;
                    if (s_reg.sbit == 3'h7) begin
                        s_next.img_data  = {s_reg.s2[SY_SMOSI], s_reg.sbyte[7:1]};
                        s_next.img_valid = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // serial pins now belong to the peripheral master
                s_next.sclk_out  = pm_sclk;
                s_next.scs_out   = pm_cs_n;
                s_next.smosi_out = pm_mosi;
            end
            default: begin
                s_next = TOP_RST;
            end
        endcase

        // image accepted: end boot, hand pins to peripheral master
        if (boot_ok && s_reg.st != ST_STRAP && s_reg.st != ST_RUN) begin
            s_next.st         = ST_RUN;
            s_next.booted     = 1'b1;
            s_next.fcs_n      = 1'b1;
            s_next.line_oe_n  = 4'hF;
            s_next.sclk_oe_n  = 1'b0;
            s_next.sclk_out   = 1'b0;
            s_next.scs_oe_n   = 1'b0;
            s_next.scs_out    = 1'b1;
            s_next.smosi_oe_n = 1'b0;
            s_next.smiso_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= TOP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign flash_line_out  = s_reg.line_out;
    assign flash_line_oe_n = s_reg.line_oe_n;
    assign flash_cs_n      = s_reg.fcs_n;
    assign sclk_out        = s_reg.sclk_out;
    assign sclk_oe_n       = s_reg.sclk_oe_n;
    assign scs_n_out       = s_reg.scs_out;
    assign scs_n_oe_n      = s_reg.scs_oe_n;
    assign smosi_out       = s_reg.smosi_out;
    assign smosi_oe_n      = s_reg.smosi_oe_n;
    assign smiso_out       = s_reg.smiso_out;
    assign smiso_oe_n      = s_reg.smiso_oe_n;
    assign img_data        = s_reg.img_data;
    assign img_valid       = s_reg.img_valid;
    assign boot_slave      = s_reg.slave;
    assign booted          = s_reg.booted;

endmodule : bil_top

// >>> bil_pkg.sv
// constants, types and helpers shared by the boot image loader
// Function
// - strap high at start: slave boot
// - strap low or floating: flash boot
// - flash boot drives select, clock, data
// - read command then 24-bit zero address
// - flash nibbles arrive low nibble first
// - slave boot bytes arrive lsb first
// - host drives clock/select/mosi; device drives miso
// - peripheral master only after successful boot
// - peripheral clock 1 MHz, writes max 128
// - peripheral reads limited to 56 bytes
// - flash uses three-byte addresses
// - quad io read opcode, one dummy byte
package bil_pkg;

    // ------------------------------------------------------------
    // clock rates and timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam int unsigned PER_CLK_HZ    = 1_000_000;
    localparam int unsigned PER_HALF_CYC  = SYS_CLK_HZ / (2 * PER_CLK_HZ);
    localparam logic [7:0]  FLASH_HALF_DEF = 8'h04;
    localparam logic [1:0]  STRAP_WAIT    = 2'h3;

    // ------------------------------------------------------------
    // flash read sequence
    // ------------------------------------------------------------
    localparam logic [7:0]  FLASH_RD_OPC      = 8'hEB;
    localparam logic [23:0] FLASH_START_ADDR  = 24'h000000;
    localparam logic [4:0]  FLASH_OPC_BITS    = 5'h08;
    localparam logic [4:0]  FLASH_ADDR_NIBS   = 5'h06;
    localparam logic [4:0]  FLASH_DUMMY_NIBS  = 5'h02;

    // ------------------------------------------------------------
    // peripheral transfer limits
    // ------------------------------------------------------------
    localparam logic [7:0]  PER_WR_MAX = 8'h80;
    localparam logic [7:0]  PER_RD_MAX = 8'h38;

    // ------------------------------------------------------------
    // pin and sync indices
    // ------------------------------------------------------------
    localparam int unsigned SY_SCLK  = 4;
    localparam int unsigned SY_SCS   = 5;
    localparam int unsigned SY_SMOSI = 6;
    localparam int unsigned SY_SMISO = 7;
    localparam int unsigned SY_STRAP = 1;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STRAP  = 3'h0,
        ST_FCMD   = 3'h1,
        ST_FADDR  = 3'h3,
        ST_FDUMMY = 3'h2,
        ST_FDATA  = 3'h6,
        ST_RUN    = 3'h7,
        ST_SRECV  = 3'h4
    } bil_state_t;

    typedef enum logic [1:0] {
        PM_IDLE  = 2'h0,
        PM_LOAD  = 2'h1,
        PM_SHIFT = 2'h3,
        PM_END   = 2'h2
    } bil_pm_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bil_sat_len(input logic [7:0] len, input logic [7:0] lim);
        bil_sat_len = (len > lim) ? lim : len;
    endfunction : bil_sat_len

    function automatic logic [3:0] bil_addr_nib(input logic [4:0] idx);
        logic [23:0] sh;
        sh = FLASH_START_ADDR >> (5'd20 - 5'(idx * 5'd4));
        bil_addr_nib = sh[3:0];
    endfunction : bil_addr_nib

endpackage : bil_pkg

// >>> bil_per_master.sv
// peripheral spi master, mode 0, msb first, length limited
`timescale 1ns/100ps
module bil_per_master
    import bil_pkg::*;
#(
    parameter int unsigned HALF_CYC = PER_HALF_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] wr_len,
    input  wire logic [7:0] rd_len,
    input  wire logic [7:0] wdata,
    input  wire logic       wvalid,
    output logic            wready,
    output logic [7:0]      rdata,
    output logic            rvalid,
    output logic            busy,
    output logic            sclk,
    output logic            cs_n,
    output logic            mosi,
    input  wire logic       miso
);

    typedef struct packed {
        bil_pm_state_t st;
        logic [7:0]    cnt;
        logic          sclk;
        logic [2:0]    bitc;
        logic [7:0]    wleft;
        logic [7:0]    rleft;
        logic [7:0]    sh;
        logic          capt;
        logic          cs_n;
        logic          mosi;
        logic          wready;
        logic [7:0]    rdata;
        logic          rvalid;
        logic          busy;
    } bil_pm_t;

    localparam bil_pm_t PM_RST = '{st: PM_IDLE, cs_n: 1'b1, default: '0};
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    bil_pm_t s_reg;
    bil_pm_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.rvalid = 1'b0;
        unique case (s_reg.st)
            PM_IDLE: begin
                // clamp lengths
                if (start && (wr_len != 8'h00 || rd_len != 8'h00)) begin
                    s_next.wleft = bil_sat_len(wr_len, PER_WR_MAX);
                    s_next.rleft = bil_sat_len(rd_len, PER_RD_MAX);
                    s_next.cs_n  = 1'b0;
                    s_next.busy  = 1'b1;
                    s_next.cnt   = 8'h00;
                    s_next.bitc  = 3'h0;
                    s_next.sh    = 8'h00;
                    s_next.mosi  = 1'b0;
                    if (wr_len != 8'h00) begin
                        s_next.st     = PM_LOAD;
                        s_next.wready = 1'b1;
                    end else begin
                        s_next.st = PM_SHIFT;
                    end
                end
            end
            PM_LOAD: begin
                if (wvalid) begin
                    s_next.wready = 1'b0;
                    s_next.sh     = wdata;
                    s_next.mosi   = wdata[7];
                    s_next.st     = PM_SHIFT;
                    s_next.cnt    = 8'h00;
                end
            end
            PM_SHIFT: begin
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == HALF_M1) begin
                    s_next.cnt  = 8'h00;
                    s_next.sclk = ~s_reg.sclk;
                    if (!s_reg.sclk) begin
                        s_next.capt = miso;
                    end else begin
                        s_next.sh   = {s_reg.sh[6:0], s_reg.capt};
                        s_next.mosi = s_reg.sh[6];
                        s_next.bitc = s_reg.bitc + 3'h1;
                        if (s_reg.bitc == 3'h7) begin
                            if (s_reg.wleft != 8'h00) begin
                                s_next.wleft = s_reg.wleft - 8'h01;
                                if (s_reg.wleft != 8'h01) begin
                                    s_next.st     = PM_LOAD;
                                    s_next.wready = 1'b1;
                                end else if (s_reg.rleft != 8'h00) begin
                                    s_next.sh   = 8'h00;
                                    s_next.mosi = 1'b0;
                                end else begin
                                    s_next.st = PM_END;
                                end
                            end else begin
                                s_next.rdata  = {s_reg.sh[6:0], s_reg.capt};
                                s_next.rvalid = 1'b1;
                                s_next.rleft  = s_reg.rleft - 8'h01;
                                s_next.sh     = 8'h00;
                                s_next.mosi   = 1'b0;
                                if (s_reg.rleft == 8'h01) begin
                                    s_next.st = PM_END;
                                end
                            end
                        end
                    end
                end
            end
            PM_END: begin
                // hold select one half period past the last edge
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == HALF_M1) begin
                    s_next.cs_n = 1'b1;
                    s_next.busy = 1'b0;
                    s_next.mosi = 1'b0;
                    s_next.st   = PM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= PM_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wready = s_reg.wready;
    assign rdata  = s_reg.rdata;
    assign rvalid = s_reg.rvalid;
    assign busy   = s_reg.busy;
    assign sclk   = s_reg.sclk;
    assign cs_n   = s_reg.cs_n;
    assign mosi   = s_reg.mosi;

endmodule : bil_per_master

// >>> bil_assertions.sv
// concurrent checks on the boot image loader top ports
`timescale 1ns/100ps
module bil_checker
    import bil_pkg::*;
#(
    parameter logic [7:0]  FLASH_HALF = FLASH_HALF_DEF,
    parameter int unsigned PER_HALF   = PER_HALF_CYC
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [3:0] flash_line_out,
    input wire logic [3:0] flash_line_oe_n,
    input wire logic       flash_cs_n,
    input wire logic       sclk_out,
    input wire logic       sclk_oe_n,
    input wire logic       scs_n_out,
    input wire logic       scs_n_oe_n,
    input wire logic       smosi_oe_n,
    input wire logic       smiso_out,
    input wire logic       smiso_oe_n,
    input wire logic       img_valid,
    input wire logic       boot_ok,
    input wire logic       boot_slave,
    input wire logic       booted,
    input wire logic       per_rvalid,
    input wire logic       per_busy
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // phase length of 4 matches the flash default half period and the bench's shortened PER_HALF
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    strap_held_a: assert property (boot_slave |=> boot_slave)
        else $error("boot path changed without reset");
    slave_pins_a: assert property (boot_slave && !booted |->
        !smiso_oe_n && !smiso_out && sclk_oe_n && scs_n_oe_n && smosi_oe_n && flash_cs_n)
        else $error("slave boot pin drive wrong");
    flash_start_a: assert property ($fell(flash_cs_n) |-> !boot_slave && !booted
        && flash_line_oe_n == 4'hE && flash_line_out[0]) else $error("flash start wrong");
    flash_clk_a: assert property (!flash_cs_n |-> !sclk_oe_n && !booted)
        else $error("flash clock not driven");
    clk_phase_a: assert property ($rose(sclk_out) |-> sclk_out[*4] ##1 !sclk_out)
        else $error("clock high phase length wrong");
    no_early_a: assert property (!booted |-> !per_busy && scs_n_oe_n)
        else $error("peripheral active before boot");
    boot_exit_a: assert property ($rose(booted) |-> $past(boot_ok) && flash_cs_n)
        else $error("boot left without boot_ok");
    sel_held_a: assert property (per_busy && $past(per_busy) |-> !scs_n_out && !scs_n_oe_n)
        else $error("select released mid transfer");
    img_pulse_a: assert property (img_valid |=> !img_valid[*8])
        else $error("image bytes too close");
    rd_pulse_a: assert property (per_rvalid |=> !per_rvalid[*8])
        else $error("read bytes too close");
    cover property (img_valid && boot_slave);
    cover property (img_valid && !boot_slave);
    cover property (per_rvalid);
endmodule : bil_checker

bind bil_top bil_checker #(.FLASH_HALF(FLASH_HALF), .PER_HALF(PER_HALF)) bil_checker_i (.*);

// >>> bil_flash_model.sv
// quad flash partner answering the fast quad read
`timescale 1ns/100ps
module bil_flash_model (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic [3:0] pins,
    output logic [3:0]      d,
    output logic            oe,
    output logic [7:0]      cmd,
    output logic [23:0]     addr
);
    int         n_rise, n_fall, k;
    logic [7:0] b;
    initial oe = 1'b0;
    always @(negedge cs_n) begin
        n_rise = 0;
        n_fall = 0;
    end
    always @(posedge cs_n) oe <= 1'b0;
    always @(posedge sclk) if (!cs_n) begin
        if (n_rise < 8) cmd <= {cmd[6:0], pins[0]};
        else if (n_rise < 14) addr <= {addr[19:0], pins};
        n_rise = n_rise + 1;
    end
    // one dummy byte, then quad data low nibble first
    always @(negedge sclk) if (!cs_n) begin
        n_fall = n_fall + 1;
        k = n_fall - 16;
        b = 8'(k / 2) * 8'h1D + 8'h5A;
        oe <= k >= 0;
        d <= (k % 2 == 1) ? b[7:4] : b[3:0];
    end
endmodule : bil_flash_model

// >>> test_bil_top.sv
// self-checking bench for the boot image loader
`timescale 1ns/100ps
module test_bil_top;
    import bil_pkg::*;
    logic [3:0]  flash_line_out, flash_line_oe_n, flt, fm_d;
    logic [7:0]  img_data, per_rdata, per_wr_len, per_rd_len, per_wdata, fm_cmd, sh_o, sh_i;
    logic [23:0] fm_addr;
    logic        sys_clk, rst, boot_ok, per_start, per_wvalid, strap, strap_ph, fm_oe;
    logic        flash_cs_n, sclk_out, sclk_oe_n, scs_n_out, scs_n_oe_n, smosi_out, smosi_oe_n;
    logic        smiso_out, smiso_oe_n, img_valid, boot_slave, booted, per_wready;
    logic        per_rvalid, per_busy, h_clk, h_cs_n, h_mosi, p_miso;
    wire logic [3:0] fl_pin;
    wire logic   sclk_pin, scs_pin, mosi_pin, miso_pin;
    int          fail_count, n_compared, seed, n_img, n_w, n_r, bits, wsat, i;
    logic [7:0]  exp_q[$], wq[$], rq[$];
    // ----------------------------------------
    // design, partner and pin levels
    // ----------------------------------------
    bil_top #(.PER_HALF(4)) bil_top_i (.flash_line_in(fl_pin), .sclk_in(sclk_pin),
        .scs_n_in(scs_pin), .smosi_in(mosi_pin), .smiso_in(miso_pin), .*);
    bil_flash_model bil_flash_model_i (.sclk(sclk_pin), .cs_n(flash_cs_n), .pins(fl_pin),
        .d(fm_d), .oe(fm_oe), .cmd(fm_cmd), .addr(fm_addr));
    // undriven lines toggle so a stale value never passes
    assign fl_pin   = (~flash_line_oe_n & flash_line_out) | (flash_line_oe_n & (fm_oe ? fm_d : flt));
    assign sclk_pin = sclk_oe_n ? h_clk : sclk_out;
    assign scs_pin  = scs_n_oe_n ? h_cs_n : scs_n_out;
    assign mosi_pin = smosi_oe_n ? h_mosi : smosi_out;
    assign miso_pin = smiso_oe_n ? p_miso : smiso_out;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) flt <= strap_ph ? {2'b00, strap, 1'b0} : ~flt;
    always @(posedge sys_clk) begin
        if (img_valid === 1'b1) begin
            n_img++;
            check(img_data, exp_q.pop_front());
        end
        if (per_rvalid === 1'b1) begin
            n_r++;
            check(per_rdata, rq.pop_front());
        end
        if (per_wvalid && per_wready === 1'b1) begin
            n_w++;
            wq.push_back(per_wdata);
            per_wdata <= 8'($random(seed));
        end
    end
    always @(posedge sclk_pin) if (booted === 1'b1 && scs_pin === 1'b0) begin
        sh_o = {sh_o[6:0], mosi_pin};
        sh_i = {sh_i[6:0], miso_pin};
        bits++;
        if (bits % 8 == 0 && bits <= wsat * 8) check(sh_o, wq.pop_front());
        else if (bits % 8 == 0) rq.push_back(sh_i);
    end
    always @(negedge sclk_pin) p_miso <= 1'($random(seed));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic do_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        strap_ph <= 1'b1;
        exp_q.delete();
        n_img = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        strap_ph <= 1'b0;
    endtask : do_reset
    task automatic per_xfer(input int wl, input int rl);
        wsat = wl > 128 ? 128 : wl;
        n_w = 0;
        n_r = 0;
        bits = 0;
        per_wr_len <= 8'(wl);
        per_rd_len <= 8'(rl);
        per_wvalid <= 1'b1;
        per_start <= 1'b1;
        @(posedge sys_clk);
        per_start <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(per_busy, 1'b1);
        for (i = 0; per_busy === 1'b1 && i < 40000; i++) @(posedge sys_clk);
        per_wvalid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(n_w, wsat);
        check(n_r, rl > 56 ? 56 : rl);
        check(bits, (wsat + (rl > 56 ? 56 : rl)) * 8);
        $display("peripheral transfer %0d/%0d done", wl, rl);
    endtask : per_xfer
    task automatic host_frame(input logic [7:0] b, input int nb);
        h_cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // host clocks bits in lsb first, clock still outside frames
        for (int k = 0; k < nb; k++) begin
            h_mosi <= b[k];
            repeat (4) @(posedge sys_clk);
            h_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            h_clk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        h_cs_n <= 1'b1;
        h_mosi <= ~h_mosi;
        repeat (8) @(posedge sys_clk);
    endtask : host_frame
    initial begin
        #400_000;
        fail_count++;
        $display("mismatch at %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        {rst, h_cs_n, strap_ph} = 3'h7;
        {boot_ok, per_start, per_wvalid, strap, h_clk, h_mosi, p_miso} = 7'h00;
        {per_wr_len, per_rd_len, per_wdata, flt} = 28'h0;
        {fail_count, n_compared, n_img, bits, wsat} = '0;
        seed = 73;
        do_reset(1'b0);
        for (i = 0; i < 8; i++) exp_q.push_back(8'(i) * 8'h1D + 8'h5A);
        for (i = 0; n_img < 6 && i < 2000; i++) @(posedge sys_clk);
        check(n_img, 6);
        boot_ok <= 1'b1;
        @(posedge sys_clk);
        boot_ok <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(fm_cmd, 8'hEB);
        check(fm_addr, 24'h000000);
        check(boot_slave, 1'b0);
        check(booted, 1'b1);
        check(flash_cs_n, 1'b1);
        $display("flash boot test done");
        per_xfer(2, 1);
        per_xfer(200, 100);
        do_reset(1'b1);
        check(boot_slave, 1'b1);
        per_start <= 1'b1;
        @(posedge sys_clk);
        per_start <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(per_busy, 1'b0);
        host_frame(8'hA5, 3);
        for (i = 0; i < 3; i++) begin
            exp_q.push_back(8'($random(seed)));
            host_frame(exp_q[$], 8);
        end
        check(n_img, 3);
        $display("slave boot test done");
        give_verdict();
    end
endmodule : test_bil_top
